/* File: shared/sdpc_consts.svh */
// Constants of the stepper drive protection and control block
`ifndef SDPC_CONSTS_SVH
`define SDPC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define SDPC_ADDR_CTRL      8'h00
`define SDPC_ADDR_STATUS    8'h04
`define SDPC_ADDR_IRQ_STAT  8'h08
`define SDPC_ADDR_IRQ_MASK  8'h0C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SDPC_CTRL_ALLOW_BIT 0
`define SDPC_ST_OC_BIT      0
`define SDPC_ST_OT_BIT      1
`define SDPC_ST_EN_BIT      2
`define SDPC_ST_VLOW_BIT    3
`define SDPC_ST_EXC_LSB     4
`define SDPC_ST_MODE_LSB    8
`define SDPC_CTRL_RST       32'h0000_0001
`define SDPC_MASK_RST       32'h0000_0000
`define SDPC_EXC_INIT       4'h9

// ----------------------------------------------------------------------
// Timing and thresholds
// ----------------------------------------------------------------------
`define SDPC_CLK_PERIOD_NS  8
`define SDPC_BLANK_NS       5500
`define SDPC_OC_LIMIT_MA    5500
`define SDPC_OT_LIMIT_DC    1440
`define SDPC_POR_MV         4000
`define SDPC_VDD_OK_MV      4750
`define SDPC_SEQ_DIV        4

`endif

/* File: shared/sdpc_pkg.sv */
// Types of the stepper drive protection and control block
package sdpc_pkg;

    typedef logic [7:0]  sdpc_addr_t;
    typedef logic [31:0] sdpc_data_t;

    typedef struct packed {
        sdpc_addr_t awaddr;
        logic       awvalid;
        sdpc_data_t wdata;
        logic [3:0] wstrb;
        logic       wvalid;
        logic       bready;
        sdpc_addr_t araddr;
        logic       arvalid;
        logic       rready;
    } sdpc_axi_req_s;

    typedef struct packed {
        logic       awready;
        logic       wready;
        logic [1:0] bresp;
        logic       bvalid;
        logic       arready;
        sdpc_data_t rdata;
        logic [1:0] rresp;
        logic       rvalid;
    } sdpc_axi_rsp_s;

    // Active-high excitation of the four windings
    typedef struct packed {
        logic bb;
        logic b;
        logic ab;
        logic a;
    } sdpc_phase_s;

    typedef enum logic [1:0] {
        SDPC_RESP_OKAY   = 2'b00,
        SDPC_RESP_SLVERR = 2'b10
    } sdpc_resp_e;

    typedef enum logic [1:0] {
        SDPC_MODE_RESET = 2'b00,
        SDPC_MODE_RUN   = 2'b01,
        SDPC_MODE_HALT  = 2'b10,
        SDPC_MODE_TRIP  = 2'b11
    } sdpc_mode_e;

endpackage

/* File: src/sdpc_blank.sv */
// Overcurrent blanking timer started by each chopping on-period
`timescale 1ns/10ps
module sdpc_blank #(
    parameter int unsigned CYC = 688
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic clr,
    input  wire logic chop_on,
    output logic      window
);
    localparam int unsigned CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYC - 1);

    logic          chop_d_ff;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    wire           rise = chop_on & ~chop_d_ff;
    wire           busy = rise | (cnt_ff != '0);

    assign nxt_cnt = clr  ? '0 :
                     rise ? LOAD :
                     (cnt_ff != '0) ? cnt_ff - CW'(1) : '0;
    // Detection only after the dead time of the on-period
    assign window = chop_on & ~busy & ~clr;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            chop_d_ff <= 1'b0;
            cnt_ff    <= '0;
        end else begin
            chop_d_ff <= chop_on;
            cnt_ff    <= nxt_cnt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_blank_load: assert property (rise && !clr |=> cnt_ff == LOAD)
        else $error("blank timer not loaded on on-period start");
    a_blank_quiet: assert property ((rise && !clr) |-> !window [*8])
        else $error("overcurrent window open during dead time");
endmodule

/* File: src/sdpc_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module sdpc_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // Only the second stage is visible to the rest of the block
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

/* File: src/sdpc_top.sv */
// Stepper drive protection and control with AXI4-Lite registers
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`include "sdpc_consts.svh"
module sdpc_top #(
    parameter int unsigned SEQ_DIV     = `SDPC_SEQ_DIV,
    parameter logic [15:0] OC_LIMIT_MA = 16'(`SDPC_OC_LIMIT_MA),
    parameter logic [15:0] OT_LIMIT_DC = 16'(`SDPC_OT_LIMIT_DC),
    parameter logic [15:0] POR_MV      = 16'(`SDPC_POR_MV),
    parameter logic [15:0] VDD_OK_MV   = 16'(`SDPC_VDD_OK_MV)
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   phase_a_in_n,
    input  wire logic                   phase_a_inv_in_n,
    input  wire logic                   phase_b_in_n,
    input  wire logic                   phase_b_inv_in_n,
    input  wire logic                   drive_en,
    input  wire logic                   sys_rst_n,
    input  wire logic                   chop_on,
    input  wire logic [15:0]            cur_ma,
    input  wire logic [15:0]            temp_dc,
    input  wire logic [15:0]            vdd_mv,
    output sdpc_pkg::sdpc_phase_s       exc_ff,
    output logic                        fault_n_o_ff,
    output logic                        fault_n_oe_ff,
    output logic                        irq_ff,
    input  wire sdpc_pkg::sdpc_axi_req_s axi_req,
    output sdpc_pkg::sdpc_axi_rsp_s     axi_rsp
);
    import sdpc_pkg::*;

    localparam int unsigned BLANK_CYC =
        (`SDPC_BLANK_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS;
    localparam int unsigned SW = $clog2(SEQ_DIV + 1);
    localparam logic [SW-1:0] SEQ_LAST = SW'(SEQ_DIV - 1);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [6:0] pins_s;
    sdpc_sync #(
        .W       (7),
        .RST_VAL (7'h0F)
    ) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .din     ({chop_on, sys_rst_n, drive_en, phase_b_inv_in_n,
                   phase_b_in_n, phase_a_inv_in_n, phase_a_in_n}),
        .dout    (pins_s)
    );

    wire  chop_s = pins_s[6];
    wire  rst_s  = pins_s[5];
    wire  en_s   = pins_s[4];
    sdpc_phase_s req_ph;
    assign req_ph = sdpc_phase_s'(~pins_s[3:0]);

    // ------------------------------------------------------------------
    // System reset
    // ------------------------------------------------------------------
    logic por_ok_ff;
    logic vdd_low_ff;
    // Reset pin low or supply at or under the power-on level holds the mode, sequencer, blanking timer and drives in reset
    wire  sys_hold = ~rst_s | ~por_ok_ff;

    // ------------------------------------------------------------------
    // Protection detection
    // ------------------------------------------------------------------
    logic oc_win;
    sdpc_blank #(
        .CYC     (BLANK_CYC)
    ) u_blank (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clr     (sys_hold),
        .chop_on (chop_s),
        .window  (oc_win)
    );

    wire oc_hit = oc_win & (cur_ma > OC_LIMIT_MA);
    wire ot_hit = temp_dc >= OT_LIMIT_DC;
    wire trip   = oc_hit | ot_hit;

    // ------------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------------
    sdpc_mode_e mode_ff;
    sdpc_mode_e nxt_mode;

    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            // A detection in the first cycle after reset must still latch
            SDPC_MODE_RESET: begin
                if (trip) nxt_mode = SDPC_MODE_TRIP;
                else if (en_s) nxt_mode = SDPC_MODE_RUN;
                else nxt_mode = SDPC_MODE_HALT;
            end
            SDPC_MODE_RUN: begin
                if (trip) nxt_mode = SDPC_MODE_TRIP;
                else if (!en_s) nxt_mode = SDPC_MODE_HALT;
            end
            SDPC_MODE_HALT: begin
                if (trip) nxt_mode = SDPC_MODE_TRIP;
                else if (en_s) nxt_mode = SDPC_MODE_RUN;
            end
            SDPC_MODE_TRIP: nxt_mode = SDPC_MODE_TRIP;
        endcase
        if (sys_hold) nxt_mode = SDPC_MODE_RESET;
    end

    // ------------------------------------------------------------------
    // Excitation sequencer
    // ------------------------------------------------------------------
    logic [SW-1:0] seq_cnt_ff;
    sdpc_phase_s   state_ff;
    sdpc_phase_s   nxt_state;
    logic [31:0]   ctrl_ff;

    wire run      = (mode_ff == SDPC_MODE_RUN) & en_s;
    // Sequencer divider stops while disabled, so the state does not sample the phase inputs
    wire seq_tick = run & (seq_cnt_ff == SEQ_LAST);
    // System reset cuts the drives at the next edge, even from run
    wire drive_ok = run & ctrl_ff[`SDPC_CTRL_ALLOW_BIT] & ~trip & ~sys_hold;

    always_comb begin
        nxt_state = state_ff;
        if (sys_hold) begin
            nxt_state = sdpc_phase_s'(`SDPC_EXC_INIT);
        end else if (seq_tick) begin
            nxt_state = req_ph;
            // Conflicting pair requests leave that pair off
            if (req_ph.a & req_ph.ab) begin
                nxt_state.a  = 1'b0;
                nxt_state.ab = 1'b0;
            end
            if (req_ph.b & req_ph.bb) begin
                nxt_state.b  = 1'b0;
                nxt_state.bb = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            por_ok_ff  <= 1'b0;
            vdd_low_ff <= 1'b1;
            mode_ff    <= SDPC_MODE_RESET;
            seq_cnt_ff <= '0;
            state_ff   <= sdpc_phase_s'(`SDPC_EXC_INIT);
        end else begin
            por_ok_ff  <= vdd_mv > POR_MV;
            vdd_low_ff <= vdd_mv < VDD_OK_MV;
            mode_ff    <= nxt_mode;
            seq_cnt_ff <= (sys_hold | seq_tick) ? '0 :
                          run ? seq_cnt_ff + SW'(1) : seq_cnt_ff;
            state_ff   <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            exc_ff        <= '0;
            fault_n_o_ff  <= 1'b0;
            fault_n_oe_ff <= 1'b0;
        end else begin
            exc_ff        <= drive_ok ? state_ff : '0;
            fault_n_o_ff  <= 1'b0;
            fault_n_oe_ff <= nxt_mode == SDPC_MODE_TRIP;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [31:0] mask_ff;
    logic [1:0] istat_ff;

    wire aw_hs  = axi_req.awvalid & axi_rsp.awready;
    wire w_hs   = axi_req.wvalid & axi_rsp.wready;
    wire aw_hav = aw_got_ff | aw_hs;
    wire w_hav  = w_got_ff | w_hs;
    wire wr_go  = aw_hav & w_hav & ~axi_rsp.bvalid;
    wire nxt_bvalid = wr_go | (axi_rsp.bvalid & ~axi_req.bready);
    wire nxt_aw_got = aw_hav & ~wr_go;
    wire nxt_w_got  = w_hav & ~wr_go;

    wire [7:0]  wr_addr = aw_got_ff ? awaddr_ff : axi_req.awaddr;
    wire [31:0] wr_data = w_got_ff ? wdata_ff : axi_req.wdata;
    wire [3:0]  wr_strb = w_got_ff ? wstrb_ff : axi_req.wstrb;
    wire wr_ctrl = wr_go & (wr_addr == `SDPC_ADDR_CTRL);
    wire wr_mask = wr_go & (wr_addr == `SDPC_ADDR_IRQ_MASK);
    wire wr_ok   = wr_addr == `SDPC_ADDR_CTRL ||
                   wr_addr == `SDPC_ADDR_STATUS ||
                   wr_addr == `SDPC_ADDR_IRQ_STAT ||
                   wr_addr == `SDPC_ADDR_IRQ_MASK;
    wire [31:0] bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                         {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    wire rd_go = axi_req.arvalid & axi_rsp.arready;
    wire nxt_rvalid = rd_go | (axi_rsp.rvalid & ~axi_req.rready);
    wire rd_stat = rd_go & (axi_req.araddr == `SDPC_ADDR_IRQ_STAT);

    logic [31:0] status_w;
    always_comb begin
        status_w = '0;
        status_w[`SDPC_ST_OC_BIT]   = istat_ff[0];
        status_w[`SDPC_ST_OT_BIT]   = istat_ff[1];
        status_w[`SDPC_ST_EN_BIT]   = en_s;
        status_w[`SDPC_ST_VLOW_BIT] = vdd_low_ff;
        status_w[`SDPC_ST_EXC_LSB +: 4]  = state_ff;
        status_w[`SDPC_ST_MODE_LSB +: 2] = mode_ff;
    end

    logic [31:0] rd_data;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (axi_req.araddr)
            `SDPC_ADDR_CTRL:     rd_data = ctrl_ff;
            `SDPC_ADDR_STATUS:   rd_data = status_w;
            `SDPC_ADDR_IRQ_STAT: rd_data = {30'h0, istat_ff};
            `SDPC_ADDR_IRQ_MASK: rd_data = mask_ff;
            default: begin
                rd_data = '0;
                rd_ok   = 1'b0;
            end
        endcase
    end

    // Events are fresh trips only; set beats a clearing read
    wire [1:0] ev = {ot_hit, oc_hit} & {2{nxt_mode == SDPC_MODE_TRIP &&
                                          mode_ff != SDPC_MODE_TRIP}};
    wire [1:0] nxt_istat = (rd_stat ? 2'b00 : istat_ff) | ev;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            axi_rsp   <= '0;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
            ctrl_ff   <= `SDPC_CTRL_RST;
            mask_ff   <= `SDPC_MASK_RST;
            istat_ff  <= '0;
            irq_ff    <= 1'b0;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff  <= nxt_w_got;
            if (aw_hs) awaddr_ff <= axi_req.awaddr;
            if (w_hs) wdata_ff <= axi_req.wdata;
            if (w_hs) wstrb_ff <= axi_req.wstrb;
            axi_rsp.awready <= ~nxt_aw_got & ~nxt_bvalid;
            axi_rsp.wready  <= ~nxt_w_got & ~nxt_bvalid;
            axi_rsp.bvalid  <= nxt_bvalid;
            if (wr_go) axi_rsp.bresp <= wr_ok ? SDPC_RESP_OKAY
                                              : SDPC_RESP_SLVERR;
            axi_rsp.arready <= ~nxt_rvalid;
            axi_rsp.rvalid  <= nxt_rvalid;
            if (rd_go) axi_rsp.rdata <= rd_data;
            if (rd_go) axi_rsp.rresp <= rd_ok ? SDPC_RESP_OKAY
                                              : SDPC_RESP_SLVERR;
            if (wr_ctrl) ctrl_ff <= (ctrl_ff & ~bmask) | (wr_data & bmask);
            if (wr_mask) mask_ff <= (mask_ff & ~bmask) | (wr_data & bmask);
            istat_ff <= nxt_istat;
            irq_ff   <= |(nxt_istat & mask_ff[1:0]);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_trip_pulls_low: assert property (mode_ff == SDPC_MODE_TRIP |->
        fault_n_oe_ff && !fault_n_o_ff)
        else $error("trip output not pulled low during trip");
    a_disable_off: assert property (!en_s |=> exc_ff == '0)
        else $error("drives on while enable low");
    a_halt_frozen: assert property (!en_s && !sys_hold |=>
        $stable(state_ff) && $stable(seq_cnt_ff))
        else $error("sequencer moved while disabled");
    a_trip_drives_off: assert property (trip && !sys_hold |=>
        mode_ff == SDPC_MODE_TRIP ##1 exc_ff == '0)
        else $error("drives not cut after protection event");
    a_trip_sticky: assert property (mode_ff == SDPC_MODE_TRIP &&
        !sys_hold |=> mode_ff == SDPC_MODE_TRIP)
        else $error("trip left without reset");
    a_oc_trip: assert property (oc_win && cur_ma > OC_LIMIT_MA
        && !sys_hold |=> fault_n_oe_ff)
        else $error("overcurrent did not trip");
    a_ot_trip: assert property (temp_dc >= OT_LIMIT_DC &&
        !sys_hold |=> fault_n_oe_ff)
        else $error("overheat did not trip");
    a_por_hold: assert property (vdd_mv <= POR_MV |=>
        sys_hold ##1 mode_ff == SDPC_MODE_RESET)
        else $error("low supply did not hold reset");
    a_reset_init: assert property (sys_hold |=>
        state_ff == sdpc_phase_s'(`SDPC_EXC_INIT) && exc_ff == '0)
        else $error("reset did not restore initial excitation");
    a_no_shoot: assert property (!(exc_ff.a && exc_ff.ab) &&
        !(exc_ff.b && exc_ff.bb))
        else $error("both windings of a pair driven");
    a_resume_state: assert property ($rose(en_s) &&
        mode_ff == SDPC_MODE_HALT && !sys_hold |=>
        $stable(state_ff))
        else $error("state changed on resume");
    a_reset_mode_trip: assert property (mode_ff == SDPC_MODE_RESET &&
        trip && !sys_hold |=> mode_ff == SDPC_MODE_TRIP)
        else $error("trip missed right after reset");
    a_event_wins: assert property (rd_stat && ev != 2'b00 |=>
        (istat_ff & $past(ev)) == $past(ev))
        else $error("event lost to clearing read");
    a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
        axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped before bready");
    a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
        axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped before rready");
endmodule

/* File: test/sdpc_ctrl_model.sv */
// Motor controller model driving the pin side of the drive block
`timescale 1ns/10ps
module sdpc_ctrl_model (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [15:0] vdd_mv,
    input  wire logic        run,
    input  wire logic [3:0]  pat,
    input  wire logic        rst_req,
    output logic             phase_a_in_n,
    output logic             phase_a_inv_in_n,
    output logic             phase_b_in_n,
    output logic             phase_b_inv_in_n,
    output logic             drive_en,
    output logic             sys_rst_n
);
    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    logic [3:0] pin_n_ff;
    logic [3:0] low_cnt_ff;
    logic       en_ff;
    // Pattern is {bb,b,ab,a}, active high; the pins are active low
    assign {phase_b_inv_in_n, phase_b_in_n, phase_a_inv_in_n,
            phase_a_in_n} = pin_n_ff;
    // Reset pin idles high; a request gives one high-low-high pulse
    assign sys_rst_n = (low_cnt_ff == 4'h0);
    assign drive_en  = en_ff;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_n_ff   <= 4'hF;
            en_ff      <= 1'b0;
            low_cnt_ff <= 4'h0;
        end else begin
            pin_n_ff <= ~pat;
            // Gate voltage is too low to conduct safely below 4.75 V
            en_ff <= run && (vdd_mv >= 16'h128E);
            if (rst_req && low_cnt_ff == 4'h0)
                low_cnt_ff <= 4'h8;
            else if (low_cnt_ff != 4'h0)
                low_cnt_ff <= low_cnt_ff - 4'h1;
        end
    end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the stepper drive protection block
`timescale 1ns/10ps
module testbench;
    import sdpc_pkg::*;
    logic          ref_clk, rstn, an, ain, bn, bin, en, srn;
    logic          run, rst_req, chop_on, f_o, f_oe, irq;
    logic [15:0]   cur_ma, temp_dc, vdd_mv;
    logic [3:0]    pat;
    logic [1:0]    r;
    sdpc_phase_s   exc;
    sdpc_data_t    d;
    sdpc_axi_req_s req;
    sdpc_axi_rsp_s rsp;
    int            mismatches, comparisons;
    // Trip pin has a pull-up when released
    wire           pin = f_oe ? f_o : 1'b1;

    sdpc_top u_sdpc_top (.ref_clk(ref_clk), .rstn(rstn),
        .phase_a_in_n(an), .phase_a_inv_in_n(ain), .phase_b_in_n(bn),
        .phase_b_inv_in_n(bin), .drive_en(en), .sys_rst_n(srn),
        .chop_on(chop_on), .cur_ma(cur_ma), .temp_dc(temp_dc),
        .vdd_mv(vdd_mv), .exc_ff(exc), .fault_n_o_ff(f_o),
        .fault_n_oe_ff(f_oe), .irq_ff(irq), .axi_req(req), .axi_rsp(rsp));
    sdpc_ctrl_model u_sdpc_ctrl_model (.ref_clk(ref_clk), .rstn(rstn),
        .vdd_mv(vdd_mv), .run(run), .pat(pat), .rst_req(rst_req),
        .phase_a_in_n(an), .phase_a_inv_in_n(ain), .phase_b_in_n(bn),
        .phase_b_inv_in_n(bin), .drive_en(en), .sys_rst_n(srn));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // A pair asked on together is dropped as a whole
    function automatic logic [3:0] expx(input logic [3:0] p);
        expx = p;
        if (p[0] && p[1]) expx[1:0] = 2'h0;
        if (p[2] && p[3]) expx[3:2] = 2'h0;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One AXI4-Lite write (w=1) or read (w=0); result in d and r
    task automatic bus(input logic w, input sdpc_addr_t a,
                       input sdpc_data_t v);
        @(posedge ref_clk);
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= v;
        req.wstrb <= 4'hF;
        req.awvalid <= w;
        req.wvalid <= w;
        req.bready <= w;
        req.arvalid <= !w;
        req.rready <= !w;
        do begin
            @(posedge ref_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.arready) req.arvalid <= 1'b0;
        end while ((w ? rsp.bvalid : rsp.rvalid) !== 1'b1);
        d = rsp.rdata;
        r = w ? rsp.bresp : rsp.rresp;
        req.bready <= 1'b0;
        req.rready <= 1'b0;
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Whole run needs about 1250 cycles
    initial begin
        cyc(40000);
        mismatches++;
        tally_and_finish;
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        req = '0;
        run = 1'b1;
        pat = 4'h9;
        rst_req = 1'b0;
        chop_on = 1'b0;
        cur_ma = 16'h0;
        temp_dc = 16'h00FA;
        vdd_mv = 16'h1388;
        mismatches = 0;
        comparisons = 0;
        void'($urandom(68382));
        cyc(2);
        rstn <= 1'b1;
        cyc(20);
        chk(exc, 32'h9);
        bus(1'b0, 8'h04, 32'h0);
        chk(d, 32'h0000_0194);
        bus(1'b0, 8'h00, 32'h0);
        chk(d, 32'h1);
        bus(1'b0, 8'h0C, 32'h0);
        chk(d, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        chk(r, 2'h2);
        chk(d, 32'h0);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk(r, 2'h2);
        // Conflicting pairs first, then random patterns
        for (int i = 0; i < 10; i++) begin
            pat <= (i < 2) ? (i ? 4'hC : 4'h3) : 4'($urandom);
            cyc(12 + 2 * i);
            chk(exc, expx(pat));
        end
        pat <= 4'h5;
        cyc(12);
        run <= 1'b0;
        cyc(6);
        chk(exc, 32'h0);
        pat <= 4'hA;
        cyc(12);
        bus(1'b0, 8'h04, 32'h0);
        chk(d[9:2], {2'h2, 4'h5, 2'h0});
        run <= 1'b1;
        cyc(12);
        chk(exc, 32'hA);
        bus(1'b1, 8'h00, 32'h0);
        cyc(4);
        chk(exc, 32'h0);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h0C, 32'h0);
        chop_on <= 1'b1;
        cur_ma <= 16'h1770;
        cyc(600);
        chk(pin, 1'b1);
        cur_ma <= 16'h157C;
        cyc(200);
        chk(pin, 1'b1);
        cur_ma <= 16'h157D;
        cyc(4);
        chk(pin, 1'b0);
        chk(exc, 32'h0);
        chk(irq, 1'b0);
        cur_ma <= 16'h0;
        chop_on <= 1'b0;
        cyc(20);
        chk(pin, 1'b0);
        bus(1'b1, 8'h0C, 32'h3);
        cyc(3);
        chk(irq, 1'b1);
        bus(1'b0, 8'h08, 32'h0);
        chk(d, 32'h1);
        cyc(3);
        chk(irq, 1'b0);
        bus(1'b0, 8'h04, 32'h0);
        // The event read just before has emptied the overcurrent bit
        chk({d[9:8], d[0]}, 3'h6);
        rst_req <= 1'b1;
        cyc(1);
        rst_req <= 1'b0;
        cyc(30);
        chk(pin, 1'b1);
        chk(exc, 32'hA);
        temp_dc <= 16'h059F;
        cyc(10);
        chk(pin, 1'b1);
        temp_dc <= 16'h05A0;
        cyc(5);
        chk(pin, 1'b0);
        bus(1'b0, 8'h08, 32'h0);
        chk(d, 32'h2);
        temp_dc <= 16'h00FA;
        // Supply at exactly 4000 mV still holds the block in reset
        vdd_mv <= 16'h0FA0;
        cyc(6);
        chk(pin, 1'b1);
        bus(1'b0, 8'h04, 32'h0);
        chk({d[9:8], d[3]}, 3'h1);
        vdd_mv <= 16'h0FA1;
        cyc(8);
        bus(1'b0, 8'h04, 32'h0);
        chk(d[9:8], 2'h2);
        chk(exc, 32'h0);
        vdd_mv <= 16'h1388;
        cyc(16);
        chk(exc, 32'hA);
        tally_and_finish;
    end
endmodule
